/* File: mbd_addr_latch.sv */
`timescale 1ns/10ps
// low address holding register, loaded while the strobe is high
module mbd_addr_latch (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic load_i,
    input wire logic [7:0] d_i,
    output logic [7:0] q_o
);
    // registered equivalent of a transparent latch so the design stays on one clock
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            q_o <= mbd_pkg::LATCH_RST;
        else if (load_i)
            q_o <= d_i;
    end
endmodule : mbd_addr_latch

/* File: mbd_cpu_model.sv */
`timescale 1ns/10ps
// processor side of the shared bus; the address strobe lasts one clock, the caller decides how long read and write strobes are held
module mbd_cpu_model (
    input wire logic clk_i,
    output logic strobe_o,
    output logic [7:0] ad_o,
    output logic [7:0] hi_o,
    output logic rd_n_o,
    output logic wr_n_o
);
    // idle bus at time zero
    initial
    begin
        strobe_o = 1'b0;
        ad_o = 8'h00;
        hi_o = 8'h00;
        rd_n_o = 1'b1;
        wr_n_o = 1'b1;
    end
    // address phase, then data phase on the same lines
    task start(input logic [15:0] a, input logic wr, input logic [7:0] d);
        @(negedge clk_i);
        strobe_o = 1'b1;
        ad_o = a[7:0];
        hi_o = a[15:8];
        @(negedge clk_i);
        strobe_o = 1'b0;
        ad_o = wr ? d : ~a[7:0];
        wr_n_o = ~wr;
        rd_n_o = wr;
    endtask : start
    // released lines flip so a stale byte never looks valid
    task stop;
        rd_n_o = 1'b1;
        wr_n_o = 1'b1;
        ad_o = ~ad_o;
    endtask : stop
endmodule : mbd_cpu_model

/* File: mbd_decoder.sv */
`timescale 1ns/10ps
module mbd_decoder (
    input wire logic CLK_I,
    input wire logic ARST_N_I,
    input wire logic ADDR_STROBE_I,
    input wire logic [7:0] MUX_AD_I,
    output logic [7:0] MUX_AD_O,
    output logic MUX_AD_OE_O,
    input wire logic [7:0] ADDR_HI_I,
    input wire logic RD_N_I,
    input wire logic WR_N_I,
    output logic ROM_EN_N_O,
    output logic RAM_EN_N_O,
    output logic PERIPH_SEL_A_N_O,
    output logic PERIPH_SEL_B_N_O,
    output logic PERIPH_SEL_C_N_O,
    output logic PERIPH_SEL_D_N_O,
    output logic CONN_RD_N_O,
    output logic CONN_WR_N_O,
    output logic [3:0] LOW_ADDR_NIBBLE_O,
    input wire logic [7:0] EXT_DATA_BUS_I,
    output logic [7:0] EXT_DATA_BUS_O,
    output logic EXT_DATA_BUS_OE_O,
    input wire logic [7:0] SPARE_GP_PORT_I,
    output logic [7:0] SPARE_GP_PORT_O,
    output logic [7:0] SPARE_GP_PORT_OE_O,
    input wire logic [7:0] CONN_GP_I,
    output logic [7:0] CONN_GP_O,
    output logic [7:0] CONN_GP_OE_O
);
    logic [7:0] addr_lo;
    logic [15:0] addr_full;
    logic [5:0] next_sel;
    logic [5:0] sel;
    logic access;

    // active-low one-hot enable for a 16-bit address
    function automatic logic [5:0] decode_sel(input logic [15:0] a);
        logic [5:0] s;
        s = mbd_pkg::SEL_IDLE;
        if (a[15:8] <= mbd_pkg::ROM_LAST_HI)
            s[mbd_pkg::SEL_ROM] = 1'b0;
        else if (a[15:8] <= mbd_pkg::RAM_LAST_HI)
            s[mbd_pkg::SEL_RAM] = 1'b0;
        else
        begin
            unique case (a[15:12])
                mbd_pkg::PSEL_A_NIB: s[mbd_pkg::SEL_PA] = 1'b0;
                mbd_pkg::PSEL_B_NIB: s[mbd_pkg::SEL_PB] = 1'b0;
                mbd_pkg::PSEL_C_NIB: s[mbd_pkg::SEL_PC] = 1'b0;
                default: s[mbd_pkg::SEL_PD] = 1'b0;
            endcase
        end
        return s;
    endfunction : decode_sel

    // low byte held while data owns the shared lines; relies on ordering
    mbd_addr_latch u_lo_latch (
        .clk_i(CLK_I),
        .arst_n_i(ARST_N_I),
        .load_i(ADDR_STROBE_I),
        .d_i(MUX_AD_I),
        .q_o(addr_lo)
    );

    // upper byte taken live, valid for the whole cycle
    assign addr_full = {ADDR_HI_I, addr_lo};
    assign access = !RD_N_I || !WR_N_I;

    // enables only during a qualified access so idle cycles select nothing
    always_comb
    begin
        next_sel = access ? decode_sel(addr_full) : mbd_pkg::SEL_IDLE;
    end

    // registered enables keep glitches off the memory chips, at one cycle of delay
    always_ff @(posedge CLK_I or negedge ARST_N_I)
    begin
        if (!ARST_N_I)
            sel <= mbd_pkg::SEL_IDLE;
        else
            sel <= next_sel;
    end

    assign ROM_EN_N_O = sel[mbd_pkg::SEL_ROM];
    assign RAM_EN_N_O = sel[mbd_pkg::SEL_RAM];
    assign PERIPH_SEL_A_N_O = sel[mbd_pkg::SEL_PA];
    assign PERIPH_SEL_B_N_O = sel[mbd_pkg::SEL_PB];
    assign PERIPH_SEL_C_N_O = sel[mbd_pkg::SEL_PC];
    assign PERIPH_SEL_D_N_O = sel[mbd_pkg::SEL_PD];

    // strobes passed straight through to the connector
    assign CONN_RD_N_O = RD_N_I;
    assign CONN_WR_N_O = WR_N_I;
    assign LOW_ADDR_NIBBLE_O = addr_lo[3:0];

    // data buffer: toward connector on write, toward processor on read
    assign EXT_DATA_BUS_O = MUX_AD_I;
    assign EXT_DATA_BUS_OE_O = !WR_N_I && !ADDR_STROBE_I;
    assign MUX_AD_O = EXT_DATA_BUS_I;
    assign MUX_AD_OE_O = !RD_N_I && !ADDR_STROBE_I;

    // spare port is a pure pass-through, each line driven only by its owning side
    assign CONN_GP_O = SPARE_GP_PORT_I;
    assign CONN_GP_OE_O = {mbd_pkg::BYTE_W{1'b1}};
    assign SPARE_GP_PORT_O = CONN_GP_I;
    assign SPARE_GP_PORT_OE_O = {mbd_pkg::BYTE_W{1'b0}};

    // one enable low in the cycle after any access
    a_sel_onehot: assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
        $past(access) |-> $countones(~sel) == 1)
        else $error("enables not exactly one");

    // idle bus must leave every chip deselected
    a_sel_idle: assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
        !$past(access) |-> sel == mbd_pkg::SEL_IDLE)
        else $error("enable without access");

    // any low enable must trace back to a qualified access
    a_sel_cause: assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
        (sel != mbd_pkg::SEL_IDLE) |-> $past(access))
        else $error("enable with no access behind it");

    // program memory region hit
    a_rom_range: assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
        (access && addr_full[15:8] <= mbd_pkg::ROM_LAST_HI) |=> !ROM_EN_N_O)
        else $error("rom enable missing");

    // program memory enable never leaks past its region
    a_rom_only: assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
        !ROM_EN_N_O |-> $past(addr_full[15:8]) <= mbd_pkg::ROM_LAST_HI)
        else $error("rom enable outside region");

    // static memory region hit
    a_ram_range: assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
        (access && addr_full[15:8] > mbd_pkg::ROM_LAST_HI && addr_full[15:8] <= mbd_pkg::RAM_LAST_HI)
        |=> !RAM_EN_N_O)
        else $error("ram enable missing");

    // static memory enable never leaks past its region
    a_ram_only: assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
        !RAM_EN_N_O |-> ($past(addr_full[15:8]) > mbd_pkg::ROM_LAST_HI
        && $past(addr_full[15:8]) <= mbd_pkg::RAM_LAST_HI))
        else $error("ram enable outside region");

    // first peripheral region hit
    a_periph_a_hit: assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
        (access && addr_full[15:12] == mbd_pkg::PSEL_A_NIB) |=> !PERIPH_SEL_A_N_O)
        else $error("first select missing");

    // fourth peripheral region hit
    a_periph_nib: assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
        (access && addr_full[15:12] == mbd_pkg::PSEL_D_NIB) |=> !PERIPH_SEL_D_N_O)
        else $error("fourth select missing");

    // each peripheral select only for its own 4 KB window
    a_periph_a: assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
        !PERIPH_SEL_A_N_O |-> $past(addr_full[15:12]) == mbd_pkg::PSEL_A_NIB)
        else $error("first select wrong");

    a_periph_b: assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
        !PERIPH_SEL_B_N_O |-> $past(addr_full[15:12]) == mbd_pkg::PSEL_B_NIB)
        else $error("second select wrong");

    a_periph_c: assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
        !PERIPH_SEL_C_N_O |-> $past(addr_full[15:12]) == mbd_pkg::PSEL_C_NIB)
        else $error("third select wrong");

    a_periph_d: assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
        !PERIPH_SEL_D_N_O |-> $past(addr_full[15:12]) == mbd_pkg::PSEL_D_NIB)
        else $error("fourth select wrong");

    // low address must survive the data phase on the shared lines
    a_latch_hold: assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
        (!ADDR_STROBE_I ##1 !ADDR_STROBE_I) |-> $stable(LOW_ADDR_NIBBLE_O))
        else $error("low address moved");

    // a single low strobe cycle is already enough to freeze the latch
    a_latch_freeze: assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
        !ADDR_STROBE_I |=> $stable(LOW_ADDR_NIBBLE_O))
        else $error("low address changed without strobe");

    // address phase loads the latch
    a_latch_load: assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
        ADDR_STROBE_I |=> LOW_ADDR_NIBBLE_O == $past(MUX_AD_I[3:0]))
        else $error("low address not loaded");

    // connector strobes are exact copies
    a_strobe_pass: assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
        CONN_RD_N_O == RD_N_I && CONN_WR_N_O == WR_N_I)
        else $error("strobe not passed");

    // both buffer directions at once would fight on the shared lines
    a_dir_excl: assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
        (RD_N_I || WR_N_I) |-> !(EXT_DATA_BUS_OE_O && MUX_AD_OE_O))
        else $error("data buffer driven both ways");

    // write data reaches the connector unchanged
    a_wr_data: assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
        EXT_DATA_BUS_OE_O |-> EXT_DATA_BUS_O == MUX_AD_I)
        else $error("write data not passed");

    // read data returns to the processor unchanged
    a_rd_data: assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
        MUX_AD_OE_O |-> MUX_AD_O == EXT_DATA_BUS_I)
        else $error("read data not passed");

    // spare port lines driven outward only, never back toward the processor
    a_gp_out: assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
        CONN_GP_O == SPARE_GP_PORT_I && (&CONN_GP_OE_O))
        else $error("spare port not passed out");

    a_gp_in: assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
        SPARE_GP_PORT_O == CONN_GP_I && !(|SPARE_GP_PORT_OE_O))
        else $error("spare port driven from connector side");
endmodule : mbd_decoder

/* File: mbd_pkg.sv */
package mbd_pkg;
    // address map boundaries, upper byte of the 16-bit address
    localparam logic [7:0] ROM_LAST_HI = 8'h3F;
    localparam logic [7:0] RAM_LAST_HI = 8'hBF;
    // top nibble codes of the four peripheral regions
    localparam logic [3:0] PSEL_A_NIB = 4'hC;
    localparam logic [3:0] PSEL_B_NIB = 4'hD;
    localparam logic [3:0] PSEL_C_NIB = 4'hE;
    localparam logic [3:0] PSEL_D_NIB = 4'hF;
    localparam int ADDR_W = 16;
    localparam int BYTE_W = 8;
    localparam int NIB_W = 4;
    localparam logic [7:0] LATCH_RST = 8'h00;
    localparam logic [5:0] SEL_IDLE = 6'h3F;
    // enable vector bit positions
    localparam int SEL_ROM = 0;
    localparam int SEL_RAM = 1;
    localparam int SEL_PA = 2;
    localparam int SEL_PB = 3;
    localparam int SEL_PC = 4;
    localparam int SEL_PD = 5;
endpackage : mbd_pkg

/* File: muxed_bus_address_decoder_bench.sv */
`timescale 1ns/10ps
module muxed_bus_address_decoder_bench;
    logic clk, arst_n, stb, rd_n, wr_n, crd_n, cwr_n, ad_oe, ed_oe;
    logic [7:0] ad, hi, ad_o, ed_i, ed_o, spare, spare_o, spare_oe, gp, gp_o, gp_oe;
    logic [3:0] nib;
    wire logic [5:0] sel;
    int n_mismatch = 0;
    int tests_run = 0;
    int cycles = 0;
    logic [15:0] bounds [12] = '{16'h0000, 16'h3FFF, 16'h4000, 16'hBFFF, 16'hC000, 16'hCFFF,
        16'hD000, 16'hDFFF, 16'hE000, 16'hEFFF, 16'hF000, 16'hFFFF};
    mbd_cpu_model u_cpu (.clk_i(clk), .strobe_o(stb), .ad_o(ad), .hi_o(hi), .rd_n_o(rd_n), .wr_n_o(wr_n));
    mbd_decoder u_dut (.CLK_I(clk), .ARST_N_I(arst_n), .ADDR_STROBE_I(stb), .MUX_AD_I(ad), .MUX_AD_O(ad_o),
        .MUX_AD_OE_O(ad_oe), .ADDR_HI_I(hi), .RD_N_I(rd_n), .WR_N_I(wr_n), .ROM_EN_N_O(sel[0]),
        .RAM_EN_N_O(sel[1]), .PERIPH_SEL_A_N_O(sel[2]), .PERIPH_SEL_B_N_O(sel[3]), .PERIPH_SEL_C_N_O(sel[4]),
        .PERIPH_SEL_D_N_O(sel[5]), .CONN_RD_N_O(crd_n), .CONN_WR_N_O(cwr_n), .LOW_ADDR_NIBBLE_O(nib),
        .EXT_DATA_BUS_I(ed_i), .EXT_DATA_BUS_O(ed_o), .EXT_DATA_BUS_OE_O(ed_oe), .SPARE_GP_PORT_I(spare),
        .SPARE_GP_PORT_O(spare_o), .SPARE_GP_PORT_OE_O(spare_oe), .CONN_GP_I(gp), .CONN_GP_O(gp_o),
        .CONN_GP_OE_O(gp_oe));
    // free-running clock, 10 ns period
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task chk(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task finish_test;
        $display("mismatches %0d of %0d checks", n_mismatch, tests_run);
        if (n_mismatch == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : finish_test
    // a hang costs at most 2000 cycles; the whole run needs far fewer
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 2000)
        begin
            n_mismatch++;
            finish_test;
        end
    end
    // one low enable per region, indexed by the decoded top address bits
    function automatic logic [5:0] exp_sel(input logic [15:0] a);
        exp_sel = mbd_pkg::SEL_IDLE;
        if (a[15:8] <= mbd_pkg::ROM_LAST_HI) exp_sel[mbd_pkg::SEL_ROM] = 1'b0;
        else if (a[15:8] <= mbd_pkg::RAM_LAST_HI) exp_sel[mbd_pkg::SEL_RAM] = 1'b0;
        else exp_sel[mbd_pkg::SEL_PA + int'(a[13:12])] = 1'b0;
    endfunction : exp_sel
    task t_reset;
        repeat (16) @(negedge clk);
        chk(16'(sel), 16'(mbd_pkg::SEL_IDLE));
        chk(16'(nib), 16'h0000);
        arst_n = 1'b1;
    endtask : t_reset
    task t_spare;
        @(negedge clk);
        chk({gp_o, spare_o}, {spare, gp});
        chk({gp_oe, spare_oe}, 16'hFF00);
    endtask : t_spare
    // every region edge, reads and writes alternating
    task t_map;
        logic [15:0] a;
        for (int i = 0; i < 12; i++)
        begin
            a = bounds[i];
            ed_i = ~a[15:8];
            u_cpu.start(a, i[0], a[15:8]);
            @(negedge clk);
            chk(16'(sel), 16'(exp_sel(a)));
            chk(16'(nib), 16'(a[3:0]));
            chk(16'({crd_n, cwr_n, ed_oe, ad_oe}), 16'({i[0], ~i[0], i[0], ~i[0]}));
            chk(16'(i[0] ? ed_o : ad_o), 16'(i[0] ? a[15:8] : ed_i));
            u_cpu.stop;
            @(negedge clk);
            chk(16'(sel), 16'(mbd_pkg::SEL_IDLE));
        end
    endtask : t_map
    initial
    begin
        arst_n = 1'b0;
        ed_i = 8'h00;
        spare = 8'hA5;
        gp = 8'h3C;
        t_reset;
        t_spare;
        t_map;
        finish_test;
    end
endmodule : muxed_bus_address_decoder_bench
